// *** dprs_defs.svh ***
// Purpose: Timing, offset and field constants for the precharge/refresh block
// Assumes: 125 MHz ref_clk; times in picoseconds
// Notes:   Counts are derived inside the module from these figures
`ifndef DPRS_DEFS_SVH
`define DPRS_DEFS_SVH
// ==========================================
// Timing
`define DPRS_CLK_PS      8000
`define DPRS_REFI_PS     7812500
`define DPRS_REFI_HOT_PS 3900000
`define DPRS_REF_CYC_PS  127500
`define DPRS_NR_EXIT_PS  137500
`define DPRS_RD_EXIT_CK  200
`define DPRS_BURST_CK    4
// ==========================================
// Register map and fields
`define DPRS_OFF_CTRL    4'h0
`define DPRS_OFF_STAT    4'h4
`define DPRS_OFF_REFCNT  4'h8
`define DPRS_CTRL_RST    32'h0000_0200
`define DPRS_WR_MSB      11
`define DPRS_WR_LSB      9
`define DPRS_HOT_BIT     0
`define DPRS_RESP_OKAY   2'h0
`define DPRS_RESP_SLVERR 2'h2
`endif

// *** dprs_pkg.sv ***
// Purpose: Types shared by the precharge/refresh block
// Assumes: Nothing beyond SystemVerilog
// Notes:   Command pins travel together as one struct
package dprs_pkg;
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } dprs_cmd_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_REF  = 3'b001,
      ST_SELF = 3'b010,
      ST_XNR  = 3'b011,
      ST_XRD  = 3'b100
   } dprs_state_t;
endpackage

// *** dprs_core.sv ***
// Purpose: Bank precharge, auto refresh and self refresh state of the memory
// Assumes: Command pins synchronous to ref_clk; AXI4-Lite register access
// Notes:   Read/write data paths are outside this block
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "dprs_defs.svh"
module dprs_core import dprs_pkg::*; #(
   parameter int BANKS = 8,
   parameter int BA_W  = 3
) (
   input  wire logic              ref_clk,
   input  wire logic              rstn,
   input  wire dprs_cmd_t         cmd_pins,
   input  wire logic              cke,
   input  wire logic [BA_W-1:0]   bank_addr,
   input  wire logic              auto_precharge_address_bit,
   input  wire logic              write_mask_pin,
   input  wire logic              termination_control,
   output logic                   termination_resistance_on,
   output logic                   data_oe,
   output logic                   lower_byte_strobe_oe,
   output logic                   upper_byte_strobe_oe,
   input  wire logic [31:0]       s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [31:0]       s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   // ==========================================
   // Derived cycle counts
   localparam int REF_CYC_CK = (`DPRS_REF_CYC_PS + `DPRS_CLK_PS - 1) / `DPRS_CLK_PS;
   localparam int NR_EXIT_CK = (`DPRS_NR_EXIT_PS + `DPRS_CLK_PS - 1) / `DPRS_CLK_PS;
   localparam int REFI_CK    = `DPRS_REFI_PS / `DPRS_CLK_PS;
   localparam int HOT_CK     = `DPRS_REFI_HOT_PS / `DPRS_CLK_PS;
   // ==========================================
   // Command decode
   logic cs, is_act, is_rd, is_wr, is_pre, is_ref;
   assign cs     = !cmd_pins.cs_n;
   assign is_act = cs && !cmd_pins.ras_n && cmd_pins.cas_n && cmd_pins.we_n;
   assign is_rd  = cs && cmd_pins.ras_n && !cmd_pins.cas_n && cmd_pins.we_n;
   assign is_wr  = cs && cmd_pins.ras_n && !cmd_pins.cas_n && !cmd_pins.we_n;
   assign is_pre = cs && !cmd_pins.ras_n && cmd_pins.cas_n && !cmd_pins.we_n;
   assign is_ref = cs && !cmd_pins.ras_n && !cmd_pins.cas_n && cmd_pins.we_n;

   // ==========================================
   // Core state
   dprs_state_t      state_q, state_d;
   logic [9:0]       cnt_q, cnt_d;
   logic [9:0]       sref_q, sref_d;
   logic [BANKS-1:0] open_q, open_d;
   logic [4:0]       wrc_q, wrc_d;
   logic [BA_W-1:0]  wrb_q, wrb_d;
   logic [15:0]      refs_q, refs_d;
   logic             cke_q;
   logic             term_on_q, term_on_d;
   logic [31:0]      ctrl_q, ctrl_d;
   logic [2:0]       wr_field;
   logic [9:0]       sref_lim;
   logic             live;

   assign wr_field = ctrl_q[`DPRS_WR_MSB:`DPRS_WR_LSB];
   assign sref_lim = ctrl_q[`DPRS_HOT_BIT] ? 10'(HOT_CK - 1) : 10'(REFI_CK - 1);
   assign live     = cke_q && cke;

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      sref_d  = sref_q;
      open_d  = open_q;
      wrc_d   = wrc_q;
      wrb_d   = wrb_q;
      refs_d  = refs_q;
      // Recovery runs from burst end, mask pin never consulted
      if (wrc_q != 5'h00) begin
         wrc_d = wrc_q - 5'h01;
         if (wrc_q == 5'h01)
            open_d[wrb_q] = 1'b0;
      end
      case (state_q)
         ST_IDLE: begin
            if (cke_q && is_ref) begin
               refs_d = refs_q + 16'h0001;
               if (!cke) begin
                  state_d = ST_SELF;
                  sref_d  = 10'h000;
               end else begin
                  state_d = ST_REF;
                  cnt_d   = 10'(REF_CYC_CK - 1);
               end
            end else if (live) begin
               if (is_act)
                  open_d[bank_addr] = 1'b1;
               if (is_pre) begin
                  if (auto_precharge_address_bit)
                     open_d = '0;
                  else
                     open_d[bank_addr] = 1'b0;
               end
               if (is_rd && auto_precharge_address_bit)
                  open_d[bank_addr] = 1'b0;
               if (is_wr && auto_precharge_address_bit) begin
                  // Newer auto precharge write replaces a pending one
                  wrc_d = 5'(`DPRS_BURST_CK) + {2'h0, wr_field} + 5'h01;
                  wrb_d = bank_addr;
               end
            end
         end
         ST_REF: begin
            if (cnt_q == 10'h000)
               state_d = ST_IDLE;
            else
               cnt_d = cnt_q - 10'h001;
         end
         ST_SELF: begin
            sref_d = sref_q + 10'h001;
            if (sref_q >= sref_lim) begin
               sref_d = 10'h000;
               refs_d = refs_q + 16'h0001;
            end
            // Exit is taken at the first edge that sees enable high
            if (cke) begin
               state_d = ST_XNR;
               cnt_d   = 10'h000;
            end
         end
         ST_XNR: begin
            cnt_d = cnt_q + 10'h001;
            if (cnt_q == 10'(NR_EXIT_CK - 1))
               state_d = ST_XRD;
         end
         ST_XRD: begin
            cnt_d = cnt_q + 10'h001;
            if (cnt_q == 10'(`DPRS_RD_EXIT_CK - 1))
               state_d = ST_IDLE;
         end
         default: state_d = ST_IDLE;
      endcase
      term_on_d = termination_control && (state_d == ST_IDLE) && cke;
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
         cnt_q   <= 10'h000;
         sref_q  <= 10'h000;
         open_q  <= '0;
         wrc_q   <= 5'h00;
         wrb_q   <= '0;
         refs_q  <= 16'h0000;
         cke_q   <= 1'b0;
         term_on_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         sref_q  <= sref_d;
         open_q  <= open_d;
         wrc_q   <= wrc_d;
         wrb_q   <= wrb_d;
         refs_q  <= refs_d;
         cke_q   <= cke;
         term_on_q <= term_on_d;
      end
   end

   // No read path here, so data and strobes never drive in this block
   assign data_oe                   = 1'b0;
   assign lower_byte_strobe_oe      = 1'b0;
   assign upper_byte_strobe_oe      = 1'b0;
   assign termination_resistance_on = term_on_q;

   // ==========================================
   // AXI4-Lite slave
   logic        awh_q, awh_d, wh_q, wh_d, bv_q, bv_d, rv_q, rv_d;
   logic [3:0]  wa_q, wa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [3:0]  ws_q, ws_d;
   logic [1:0]  br_q, br_d, rr_q, rr_d;
   logic [31:0] stat;

   assign stat = {13'h0000, open_q, 8'h00, state_q};

   always_comb begin
      awh_d  = awh_q;
      wh_d   = wh_q;
      bv_d   = bv_q;
      rv_d   = rv_q;
      wa_d   = wa_q;
      wd_d   = wd_q;
      ws_d   = ws_q;
      br_d   = br_q;
      rd_d   = rd_q;
      rr_d   = rr_q;
      ctrl_d = ctrl_q;
      if (s_axi_awvalid && s_axi_awready) begin
         awh_d = 1'b1;
         wa_d  = s_axi_awaddr[3:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wh_d = 1'b1;
         wd_d = s_axi_wdata;
         ws_d = s_axi_wstrb;
      end
      if (awh_q && wh_q) begin
         awh_d = 1'b0;
         wh_d  = 1'b0;
         bv_d  = 1'b1;
         br_d  = `DPRS_RESP_SLVERR;
         if (wa_q == `DPRS_OFF_CTRL) begin
            br_d = `DPRS_RESP_OKAY;
            for (int i = 0; i < 4; i++) begin
               if (ws_q[i])
                  ctrl_d[i*8 +: 8] = wd_q[i*8 +: 8];
            end
         end else if (wa_q == `DPRS_OFF_STAT || wa_q == `DPRS_OFF_REFCNT) begin
            br_d = `DPRS_RESP_OKAY;
         end
      end
      if (bv_q && s_axi_bready)
         bv_d = 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
         rv_d = 1'b1;
         rr_d = `DPRS_RESP_OKAY;
         case (s_axi_araddr[3:0])
            `DPRS_OFF_CTRL:   rd_d = ctrl_q;
            `DPRS_OFF_STAT:   rd_d = stat;
            `DPRS_OFF_REFCNT: rd_d = {16'h0000, refs_q};
            default: begin
               rd_d = 32'h0000_0000;
               rr_d = `DPRS_RESP_SLVERR;
            end
         endcase
      end else if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         awh_q  <= 1'b0;
         wh_q   <= 1'b0;
         bv_q   <= 1'b0;
         rv_q   <= 1'b0;
         wa_q   <= 4'h0;
         wd_q   <= 32'h0000_0000;
         ws_q   <= 4'h0;
         br_q   <= 2'h0;
         rd_q   <= 32'h0000_0000;
         rr_q   <= 2'h0;
         ctrl_q <= `DPRS_CTRL_RST;
      end else begin
         awh_q  <= awh_d;
         wh_q   <= wh_d;
         bv_q   <= bv_d;
         rv_q   <= rv_d;
         wa_q   <= wa_d;
         wd_q   <= wd_d;
         ws_q   <= ws_d;
         br_q   <= br_d;
         rd_q   <= rd_d;
         rr_q   <= rr_d;
         ctrl_q <= ctrl_d;
      end
   end

   assign s_axi_awready = !awh_q && !bv_q;
   assign s_axi_wready  = !wh_q && !bv_q;
   assign s_axi_bvalid  = bv_q;
   assign s_axi_bresp   = br_q;
   assign s_axi_arready = !rv_q;
   assign s_axi_rvalid  = rv_q;
   assign s_axi_rdata   = rd_q;
   assign s_axi_rresp   = rr_q;

   // ==========================================
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   chk_rd_ap_close: assert property (
      (state_q == ST_IDLE && live && is_rd && auto_precharge_address_bit)
      |=> !open_q[$past(bank_addr)]) else $error("read with auto precharge left bank open");
   chk_pre_all: assert property (
      (state_q == ST_IDLE && live && is_pre && auto_precharge_address_bit)
      |=> open_q == '0) else $error("precharge all left a bank open");
   chk_ref_busy: assert property (
      (state_q == ST_IDLE && cke_q && cke && is_ref)
      |=> (state_q == ST_REF)[*8] ##1 (state_q == ST_REF)[*8] ##1 state_q == ST_IDLE)
      else $error("refresh busy period wrong");
   chk_ref_quiet: assert property (
      state_q == ST_REF |-> !data_oe && !lower_byte_strobe_oe && !upper_byte_strobe_oe)
      else $error("data pins driven during refresh");
   chk_sref_enter: assert property (
      (state_q == ST_IDLE && cke_q && !cke && is_ref) |=> state_q == ST_SELF)
      else $error("self refresh not entered");
   chk_sref_exit: assert property (
      (state_q == ST_SELF && cke) |=> (state_q == ST_XNR)[*8] ##1 (state_q == ST_XNR)[*8]
      ##1 (state_q == ST_XNR)[*2] ##1 state_q == ST_XRD)
      else $error("exit period timing wrong");
   chk_wr_recov: assert property (
      (state_q == ST_IDLE && live && is_wr && auto_precharge_address_bit)
      |=> wrc_q == 5'(`DPRS_BURST_CK) + {2'h0, wr_field} + 5'h01)
      else $error("write recovery count not loaded");
   chk_wr_close: assert property (
      (wrc_q == 5'h01) |=> !open_q[$past(wrb_q)])
      else $error("bank not closed after write recovery");

   cov_refresh: cover property (state_q == ST_REF ##1 state_q == ST_IDLE);
   cov_sref_full: cover property (state_q == ST_XRD ##1 state_q == ST_IDLE);
   cov_pre_all: cover property (live && is_pre && auto_precharge_address_bit && open_q != '0);
endmodule // dprs_core
`default_nettype wire

// *** dprs_ctl_model.sv ***
// Purpose: Controller model that drives the command pins of the block
// Assumes: Pins move by NBA just after ref_clk rises
// Notes:   Waits are minimum figures at this clock
`timescale 1ns/100ps
`default_nettype none
module dprs_ctl_model import dprs_pkg::*; #(
   parameter int RP  = 2,
   parameter int RPA = 3
) (
   input  wire logic   ref_clk,
   output dprs_cmd_t   cmd_pins,
   output logic        cke,
   output logic [2:0]  bank_addr,
   output logic        auto_precharge_address_bit,
   output logic        termination_control
);
   logic [7:0] open_q;
   initial begin
      cmd_pins = dprs_cmd_t'(4'hF);
      cke = 1'h1;
      bank_addr = 3'h0;
      auto_precharge_address_bit = 1'h0;
      termination_control = 1'h0;
      open_q = 8'h00;
   end
   // ==========================================
   // Commands
   // A short run never reaches one refresh interval
   task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic a, input int gap);
      if (c[2:1] == 2'h2 && !open_q[b])
         cmd(4'h3, b, 1'h0, 2);
      if (c == 4'h1 && open_q != 8'h00)
         cmd(4'h2, 3'h0, 1'h1, 0);
      @(posedge ref_clk);
      cmd_pins <= dprs_cmd_t'(c);
      bank_addr <= b;
      auto_precharge_address_bit <= a;
      @(posedge ref_clk);
      cmd_pins <= dprs_cmd_t'(4'h7);
      bank_addr <= ~b;
      auto_precharge_address_bit <= ~a;
      if (c == 4'h3)
         open_q[b] = 1'h1;
      if (c == 4'h2 && a)
         open_q = 8'h00;
      else if (c == 4'h2 || (c[2:1] == 2'h2 && a))
         open_q[b] = 1'h0;
      repeat (c == 4'h2 ? (a ? RPA : RP) : gap) @(posedge ref_clk);
   endtask
   task automatic term_on();
      @(posedge ref_clk);
      termination_control <= 1'h1;
   endtask
   task automatic sr_enter();
      @(posedge ref_clk);
      termination_control <= 1'h0;
      repeat (4) @(posedge ref_clk);
      if (open_q != 8'h00)
         cmd(4'h2, 3'h0, 1'h1, 0);
      @(posedge ref_clk);
      cmd_pins <= dprs_cmd_t'(4'h1);
      cke <= 1'h0;
      @(posedge ref_clk);
      cmd_pins <= dprs_cmd_t'(4'h7);
   endtask
   task automatic sr_exit();
      repeat (3) @(posedge ref_clk);
      cke <= 1'h1;
   endtask
endmodule // dprs_ctl_model
`default_nettype wire

// *** dprs_core_bench.sv ***
// Purpose: Self-checking bench for the precharge/refresh block
// Assumes: Controller model drives the command pins
// Notes:   Bus results are compared against a queue of notes
`timescale 1ns/100ps
`default_nettype none
`include "dprs_defs.svh"
module dprs_core_bench import dprs_pkg::*;;
   logic        ref_clk = 1'h0;
   logic        rstn = 1'h0;
   logic        write_mask_pin = 1'h0;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   logic [31:0] s_axi_rdata, seed = 32'h0000093C;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        tro, doe, lsoe, usoe, cke, auto_precharge_address_bit, termination_control;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [2:0]  bank_addr;
   dprs_cmd_t   cmd_pins;
   logic [34:0] exp_q[$];
   logic [34:0] e;
   int          n_errors = 0;
   int          cmp_count = 0;
   always #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk) write_mask_pin <= ~write_mask_pin;
   dprs_core dut_u (.ref_clk, .rstn, .cmd_pins, .cke, .bank_addr, .auto_precharge_address_bit,
      .write_mask_pin, .termination_control, .termination_resistance_on(tro), .data_oe(doe),
      .lower_byte_strobe_oe(lsoe), .upper_byte_strobe_oe(usoe), .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   dprs_ctl_model ctl_u (.ref_clk, .cmd_pins, .cke, .bank_addr, .auto_precharge_address_bit,
      .termination_control);
   // ==========================================
   // Helpers
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] stat(input logic [7:0] o, input logic [2:0] s);
      return {13'h0, o, 8'h00, s};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("Compares %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(negedge ref_clk) begin
      if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
         e = exp_q.pop_front();
         chk({30'h0, s_axi_rvalid ? s_axi_rresp : s_axi_bresp}, {30'h0, e[33:32]});
         if (e[34])
            chk(s_axi_rdata, e[31:0]);
      end
   end
   // Read when rd is set: d is then the expected word
   task automatic axi(input bit rd, input logic [31:0] a, input logic [31:0] d,
                      input logic [1:0] er);
      bit pa, pw, pr, ta, tw, tr;
      int n;
      exp_q.push_back({rd, er, d});
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_arvalid <= rd;
      s_axi_rready <= rd;
      s_axi_awvalid <= !rd;
      s_axi_wvalid <= !rd;
      s_axi_bready <= !rd;
      pa = 1'h1;
      pw = !rd;
      pr = 1'h1;
      n = 0;
      while ((pa || pw || pr) && n < 100) begin
         @(negedge ref_clk);
         ta = (s_axi_arvalid && s_axi_arready) || (s_axi_awvalid && s_axi_awready);
         tw = s_axi_wvalid && s_axi_wready;
         tr = (s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready);
         @(posedge ref_clk);
         if (ta) begin
            s_axi_arvalid <= 1'h0;
            s_axi_awvalid <= 1'h0;
            pa = 1'h0;
         end
         if (tw) begin
            s_axi_wvalid <= 1'h0;
            pw = 1'h0;
         end
         if (tr) begin
            s_axi_rready <= 1'h0;
            s_axi_bready <= 1'h0;
            pr = 1'h0;
         end
         n++;
      end
      if (pa || pw || pr) begin
         n_errors++;
         $display("[FAIL] %0t bus wait ran out", $time);
         end_sim();
      end
   endtask
   // ==========================================
   // Main sequence
   initial begin
      logic [2:0] b, b2;
      repeat (12) @(posedge ref_clk);
      rstn <= 1'h1;
      axi(1, `DPRS_OFF_CTRL, `DPRS_CTRL_RST, `DPRS_RESP_OKAY);
      axi(1, `DPRS_OFF_STAT, stat(8'h00, ST_IDLE), `DPRS_RESP_OKAY);
      axi(1, `DPRS_OFF_REFCNT, 32'h0, `DPRS_RESP_OKAY);
      axi(1, 32'h0000000C, 32'h0, `DPRS_RESP_SLVERR);
      axi(0, 32'h0000000C, xs(), `DPRS_RESP_SLVERR);
      axi(0, `DPRS_OFF_CTRL, 32'h00000601, `DPRS_RESP_OKAY);
      axi(1, `DPRS_OFF_CTRL, 32'h00000601, `DPRS_RESP_OKAY);
      $display("Registers done");
      for (int i = 0; i < 8; i++)
         ctl_u.cmd(4'h3, 3'(i), 1'h0, 2);
      axi(1, `DPRS_OFF_STAT, stat(8'hFF, ST_IDLE), `DPRS_RESP_OKAY);
      b = 3'(xs());
      b2 = b + 3'h1;
      ctl_u.cmd(4'h2, b, 1'h0, 0);
      axi(1, `DPRS_OFF_STAT, stat(~(8'h01 << b), ST_IDLE), `DPRS_RESP_OKAY);
      ctl_u.cmd(4'h5, b2, 1'h1, 2);
      axi(1, `DPRS_OFF_STAT, stat(~((8'h01 << b) | (8'h01 << b2)), ST_IDLE), 2'h0);
      ctl_u.cmd(4'h2, b2, 1'h1, 0);
      axi(1, `DPRS_OFF_STAT, stat(8'h00, ST_IDLE), `DPRS_RESP_OKAY);
      ctl_u.cmd(4'h4, b, 1'h1, 0);
      axi(1, `DPRS_OFF_STAT, stat(8'h01 << b, ST_IDLE), `DPRS_RESP_OKAY);
      repeat (12) @(posedge ref_clk);
      axi(1, `DPRS_OFF_STAT, stat(8'h00, ST_IDLE), `DPRS_RESP_OKAY);
      $display("Precharge done");
      ctl_u.cmd(4'h3, b2, 1'h0, 2);
      ctl_u.cmd(4'h1, b, 1'h0, 0);
      axi(1, `DPRS_OFF_STAT, stat(8'h00, ST_REF), `DPRS_RESP_OKAY);
      chk({29'h0, doe, lsoe, usoe}, 32'h0);
      repeat (16) @(posedge ref_clk);
      axi(1, `DPRS_OFF_STAT, stat(8'h00, ST_IDLE), `DPRS_RESP_OKAY);
      axi(1, `DPRS_OFF_REFCNT, 32'h1, `DPRS_RESP_OKAY);
      $display("Refresh done");
      ctl_u.term_on();
      repeat (3) @(posedge ref_clk);
      chk({31'h0, tro}, 32'h1);
      ctl_u.sr_enter();
      axi(1, `DPRS_OFF_STAT, stat(8'h00, ST_SELF), `DPRS_RESP_OKAY);
      chk({31'h0, tro}, 32'h0);
      ctl_u.sr_exit();
      axi(1, `DPRS_OFF_STAT, stat(8'h00, ST_XNR), `DPRS_RESP_OKAY);
      repeat (25) @(posedge ref_clk);
      axi(1, `DPRS_OFF_STAT, stat(8'h00, ST_XRD), `DPRS_RESP_OKAY);
      repeat (200) @(posedge ref_clk);
      axi(1, `DPRS_OFF_STAT, stat(8'h00, ST_IDLE), `DPRS_RESP_OKAY);
      $display("Self refresh done");
      ctl_u.sr_enter();
      repeat (500) @(posedge ref_clk);
      ctl_u.sr_exit();
      repeat (205) @(posedge ref_clk);
      axi(1, `DPRS_OFF_REFCNT, 32'h4, `DPRS_RESP_OKAY);
      axi(1, `DPRS_OFF_STAT, stat(8'h00, ST_IDLE), `DPRS_RESP_OKAY);
      $display("Internal refresh done");
      end_sim();
   end
endmodule // dprs_core_bench
`default_nettype wire
